// File: rtl/sir_defs.svh
// sir_defs.svh: offsets, reset values, field positions and timing counts
// assumes: included by the package and the register block, 15-bit addresses
`ifndef SIR_DEFS_SVH
`define SIR_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SIR_OFS_SETUP_B      15'h0001
`define SIR_OFS_PART_CAT     15'h0003
`define SIR_OFS_PART_ID_LO   15'h0004
`define SIR_OFS_PART_ID_HI   15'h0005
`define SIR_OFS_GRADE_REV    15'h0006
`define SIR_OFS_SCRATCH      15'h000a
`define SIR_OFS_STD_VER      15'h000b
`define SIR_OFS_MAKER_ID_LO  15'h000c
`define SIR_OFS_MAKER_ID_HI  15'h000d
`define SIR_OFS_STREAM_LEN   15'h000e
`define SIR_OFS_SETUP_C      15'h0010
`define SIR_OFS_CONDITION    15'h0011
`define SIR_OFS_CHAN_CTRL    15'h0014

// ****************************************************************
// reset values
// ****************************************************************
`define SIR_RST_SCRATCH      8'h00
`define SIR_RST_STREAM_LEN   8'h00
`define SIR_RST_SETUP_C      8'h20
`define SIR_RST_CHAN_CTRL    8'h80
`define SIR_RST_ONE_ADDR     1'h0

// ****************************************************************
// field positions and channel count
// ****************************************************************
`define SIR_BIT_ONE_ADDR     7
`define SIR_BIT_SHORT_INSTR  3
`define SIR_BIT_STRICT       5
`define SIR_BIT_NOT_READY    7
`define SIR_BIT_SINK_EN      7
`define SIR_NUM_CHAN         4

// ****************************************************************
// timing
// ****************************************************************
`define SIR_CLK_PERIOD_NS    100
`define SIR_STARTUP_NS       1000
`define SIR_STARTUP_CYC      ((`SIR_STARTUP_NS + `SIR_CLK_PERIOD_NS - 1) / `SIR_CLK_PERIOD_NS)

`endif

// File: rtl/sir_pkg.sv
// sir_pkg.sv: types shared by the serial register block
// assumes: sir_defs.svh holds the register offsets, reset values and field positions
`include "sir_defs.svh"

package sir_pkg;

    // ****************************************************************
    // frame states
    // ****************************************************************
    typedef enum logic [1:0]
    {
        SIR_IDLE,
        SIR_INSTR,
        SIR_DATA,
        SIR_HALT
    } sir_frame_t;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed
    {
        logic sclk;
        logic csb_n;
        logic sdi;
    } sir_spi_pins_t;

    typedef struct packed
    {
        logic        en;
        logic [14:0] addr;
        logic [7:0]  data;
    } sir_wr_t;

endpackage

// File: rtl/sir_regs_top.sv
// sir_regs_top.sv: serial slave port with configuration, id and status registers
// assumes: spi pins are asynchronous to core_clk_in and slow against 10 MHz
`include "sir_defs.svh"

module sir_regs_top
#(
    parameter logic [3:0]  PART_CATEGORY = 4'h3,      // arbitrary value
    parameter logic [15:0] PART_ID       = 16'h1234,  // arbitrary value
    parameter logic [3:0]  GRADE         = 4'h0,      // arbitrary value
    parameter logic [3:0]  REVISION      = 4'h1,      // arbitrary value
    parameter logic [7:0]  STD_VERSION   = 8'h11,     // arbitrary value
    parameter logic [15:0] MAKER_ID      = 16'h0abc   // arbitrary value
)
(
    input  wire logic                   core_clk_in,
    input  wire logic                   reset_in,
    input  wire sir_pkg::sir_spi_pins_t spi_in,
    input  wire logic                   addr_ascend_in,
    output logic                        sdo_out,
    output logic                        sdo_oe_out,
    output logic [3:0]                  chan_out_on_out,
    output logic                        chan0_sink_en_out
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [2:0] sclk_sync_ff;
    logic [1:0] csb_sync_ff;
    logic [1:0] sdi_sync_ff;
    logic [2:0] nxt_sclk_sync;
    logic [1:0] nxt_csb_sync;
    logic [1:0] nxt_sdi_sync;

    always_comb
    begin
        nxt_sclk_sync = {sclk_sync_ff[1:0], spi_in.sclk};
        nxt_csb_sync  = {csb_sync_ff[0], spi_in.csb_n};
        nxt_sdi_sync  = {sdi_sync_ff[0], spi_in.sdi};
    end

    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            sclk_sync_ff <= 3'h0;
            csb_sync_ff  <= 2'h3;
            sdi_sync_ff  <= 2'h0;
        end
        else
        begin
            sclk_sync_ff <= nxt_sclk_sync;
            csb_sync_ff  <= nxt_csb_sync;
            sdi_sync_ff  <= nxt_sdi_sync;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    logic sdi_bit;

    assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
    assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
    assign cs_active = ~csb_sync_ff[1];
    assign sdi_bit   = sdi_sync_ff[1];

    // ****************************************************************
    // start-up readiness
    // ****************************************************************
    logic [7:0] ready_cnt_ff;
    logic       not_ready_ff;
    logic [7:0] nxt_ready_cnt;
    logic       nxt_not_ready;

    always_comb
    begin
        nxt_ready_cnt = ready_cnt_ff;
        nxt_not_ready = 1'b0;
        if (ready_cnt_ff < 8'(`SIR_STARTUP_CYC))
        begin
            nxt_ready_cnt = ready_cnt_ff + 8'h01;
            nxt_not_ready = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ready_cnt_ff <= 8'h00;
            not_ready_ff <= 1'b0;
        end
        else
        begin
            ready_cnt_ff <= nxt_ready_cnt;
            not_ready_ff <= nxt_not_ready;
        end
    end

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    sir_pkg::sir_wr_t wr;
    logic [7:0]       scratch_ff;
    logic [7:0]       stream_len_ff;
    logic             one_addr_ff;
    logic [7:0]       chan_ff;
    logic [7:0]       nxt_scratch;
    logic [7:0]       nxt_stream_len;
    logic             nxt_one_addr;
    logic [7:0]       nxt_chan;

    always_comb
    begin
        nxt_scratch    = scratch_ff;
        nxt_stream_len = stream_len_ff;
        nxt_one_addr   = one_addr_ff;
        nxt_chan       = chan_ff;
        // writes land only once ready; read-only offsets fall through
        if (wr.en && !not_ready_ff)
        begin
            case (wr.addr)
                `SIR_OFS_SCRATCH:    nxt_scratch = wr.data;
                `SIR_OFS_STREAM_LEN: nxt_stream_len = wr.data;
                `SIR_OFS_SETUP_B:    nxt_one_addr = wr.data[`SIR_BIT_ONE_ADDR];
                `SIR_OFS_CHAN_CTRL:
                begin
                    nxt_chan[`SIR_BIT_SINK_EN] = wr.data[`SIR_BIT_SINK_EN];
                    nxt_chan[3:0] = wr.data[3:0];
                end
                default:             nxt_scratch = scratch_ff;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            scratch_ff    <= `SIR_RST_SCRATCH;
            stream_len_ff <= `SIR_RST_STREAM_LEN;
            one_addr_ff   <= `SIR_RST_ONE_ADDR;
            chan_ff       <= `SIR_RST_CHAN_CTRL;
        end
        else
        begin
            scratch_ff    <= nxt_scratch;
            stream_len_ff <= nxt_stream_len;
            one_addr_ff   <= nxt_one_addr;
            chan_ff       <= nxt_chan;
        end
    end

    // one drive bit per channel, one means normal operation
    genvar ch;
    generate
        for (ch = 0; ch < `SIR_NUM_CHAN; ch++)
        begin : g_chan
            assign chan_out_on_out[ch] = chan_ff[ch];
        end
    endgenerate

    assign chan0_sink_en_out = chan_ff[`SIR_BIT_SINK_EN];

    // ****************************************************************
    // read multiplexer
    // ****************************************************************
    function automatic logic [7:0] read_byte(input logic [14:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `SIR_OFS_SETUP_B:     d = {one_addr_ff, 3'h0, 1'b1, 3'h0};
            `SIR_OFS_PART_CAT:    d = {4'h0, PART_CATEGORY};
            `SIR_OFS_PART_ID_LO:  d = PART_ID[7:0];
            `SIR_OFS_PART_ID_HI:  d = PART_ID[15:8];
            `SIR_OFS_GRADE_REV:   d = {GRADE, REVISION};
            `SIR_OFS_SCRATCH:     d = scratch_ff;
            `SIR_OFS_STD_VER:     d = STD_VERSION;
            `SIR_OFS_MAKER_ID_LO: d = MAKER_ID[7:0];
            `SIR_OFS_MAKER_ID_HI: d = MAKER_ID[15:8];
            `SIR_OFS_STREAM_LEN:  d = stream_len_ff;
            `SIR_OFS_SETUP_C:     d = `SIR_RST_SETUP_C;
            `SIR_OFS_CONDITION:   d = {not_ready_ff, 7'h00};
            `SIR_OFS_CHAN_CTRL:   d = {chan_ff[7], 3'h0, chan_ff[3:0]};
            default:              d = 8'h00;
        endcase
        return d;
    endfunction

    // ****************************************************************
    // serial frame engine
    // ****************************************************************
    sir_pkg::sir_frame_t state_ff;
    logic [3:0]          bit_cnt_ff;
    logic [15:0]         shift_in_ff;
    logic                rd_ff;
    logic [14:0]         addr_ff;
    logic [14:0]         start_addr_ff;
    logic [7:0]          step_cnt_ff;
    logic [7:0]          shift_out_ff;
    logic                sdo_ff;
    sir_pkg::sir_frame_t nxt_state;
    logic [3:0]          nxt_bit_cnt;
    logic [15:0]         nxt_shift_in;
    logic                nxt_rd;
    logic [14:0]         nxt_addr;
    logic [14:0]         nxt_start_addr;
    logic [7:0]          nxt_step_cnt;
    logic [7:0]          nxt_shift_out;
    logic                nxt_sdo;
    logic [14:0]         step_addr;
    logic [7:0]          step_next;

    // next streaming address, direction and loop length
    always_comb
    begin
        step_next = step_cnt_ff + 8'h01;
        if (stream_len_ff != 8'h00 && step_next == stream_len_ff)
        begin
            step_addr = start_addr_ff;
            step_next = 8'h00;
        end
        else if (addr_ascend_in)
        begin
            step_addr = addr_ff + 15'h0001;
        end
        else
        begin
            step_addr = addr_ff - 15'h0001;
        end
    end

    always_comb
    begin
        nxt_state      = state_ff;
        nxt_bit_cnt    = bit_cnt_ff;
        nxt_shift_in   = shift_in_ff;
        nxt_rd         = rd_ff;
        nxt_addr       = addr_ff;
        nxt_start_addr = start_addr_ff;
        nxt_step_cnt   = step_cnt_ff;
        nxt_shift_out  = shift_out_ff;
        nxt_sdo        = sdo_ff;
        wr             = '0;
        if (!cs_active)
        begin
            nxt_state = sir_pkg::SIR_IDLE;
        end
        else
        begin
            case (state_ff)
                sir_pkg::SIR_IDLE:
                begin
                    nxt_state   = sir_pkg::SIR_INSTR;
                    nxt_bit_cnt = 4'h0;
                end
                sir_pkg::SIR_INSTR:
                begin
                    if (sclk_rise)
                    begin
                        nxt_shift_in = {shift_in_ff[14:0], sdi_bit};
                        nxt_bit_cnt  = bit_cnt_ff + 4'h1;
                        if (bit_cnt_ff == 4'hf)
                        begin
                            // long instruction word: read flag then 15 address bits
                            nxt_rd         = nxt_shift_in[15];
                            nxt_addr       = nxt_shift_in[14:0];
                            nxt_start_addr = nxt_shift_in[14:0];
                            nxt_step_cnt   = 8'h00;
                            nxt_shift_out  = read_byte(nxt_shift_in[14:0]);
                            nxt_state      = sir_pkg::SIR_DATA;
                        end
                    end
                end
                sir_pkg::SIR_DATA:
                begin
                    if (sclk_rise)
                    begin
                        nxt_shift_in = {shift_in_ff[14:0], sdi_bit};
                        nxt_bit_cnt  = {1'b0, bit_cnt_ff[2:0] + 3'h1};
                        if (bit_cnt_ff[2:0] == 3'h7)
                        begin
                            // single-byte registers here, so each byte is a whole write
                            wr.en   = ~rd_ff;
                            wr.addr = addr_ff;
                            wr.data = nxt_shift_in[7:0];
                            if (one_addr_ff)
                            begin
                                nxt_state = sir_pkg::SIR_HALT;
                            end
                            else
                            begin
                                nxt_addr      = step_addr;
                                nxt_step_cnt  = step_next;
                                nxt_shift_out = read_byte(step_addr);
                            end
                        end
                    end
                    else if (sclk_fall && rd_ff)
                    begin
                        nxt_sdo       = shift_out_ff[7];
                        nxt_shift_out = {shift_out_ff[6:0], 1'b0};
                    end
                end
                sir_pkg::SIR_HALT:
                begin
                    nxt_sdo = (sclk_fall && rd_ff) ? 1'b0 : sdo_ff;
                end
                default:
                begin
                    nxt_state = sir_pkg::SIR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_ff      <= sir_pkg::SIR_IDLE;
            bit_cnt_ff    <= 4'h0;
            shift_in_ff   <= 16'h0000;
            rd_ff         <= 1'b0;
            addr_ff       <= 15'h0000;
            start_addr_ff <= 15'h0000;
            step_cnt_ff   <= 8'h00;
            shift_out_ff  <= 8'h00;
            sdo_ff        <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            bit_cnt_ff    <= nxt_bit_cnt;
            shift_in_ff   <= nxt_shift_in;
            rd_ff         <= nxt_rd;
            addr_ff       <= nxt_addr;
            start_addr_ff <= nxt_start_addr;
            step_cnt_ff   <= nxt_step_cnt;
            shift_out_ff  <= nxt_shift_out;
            sdo_ff        <= nxt_sdo;
        end
    end

    assign sdo_out    = sdo_ff;
    assign sdo_oe_out = cs_active && rd_ff
                        && (state_ff == sir_pkg::SIR_DATA || state_ff == sir_pkg::SIR_HALT);

endmodule

// File: tb/sir_host_model.sv
// sir_host_model.sv: serial host that frames register reads and writes
// assumes: mode 0 link, pins driven on core clock edges, 8 core clocks per bit
module sir_host_model
(
    input  wire logic             core_clk_in,
    input  wire logic             sdo_in,
    output sir_pkg::sir_spi_pins_t spi_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        spi_out = '{sclk: 1'b0, csb_n: 1'b1, sdi: 1'b0};
    end

    // ****************************************************************
    // one frame: 16-bit instruction, then nbits data bits, msb first
    // ****************************************************************
    task automatic frame(input logic [15:0] instr, input int nbits,
                         input logic [63:0] wbits, output logic [63:0] rbits);
        rbits = 64'h0;
        @(posedge core_clk_in);
        spi_out.csb_n <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        for (int i = 0; i < 16 + nbits; i++)
        begin
            spi_out.sclk <= 1'b0;
            // full address in every frame, long instruction word
            spi_out.sdi  <= (i < 16) ? instr[15 - i] : wbits[nbits - 1 - (i - 16)];
            repeat (3) @(posedge core_clk_in);
            @(negedge core_clk_in);
            if (i >= 16)
            begin
                rbits[nbits - 1 - (i - 16)] = sdo_in;
            end
            @(posedge core_clk_in);
            spi_out.sclk <= 1'b1;
            repeat (4) @(posedge core_clk_in);
        end
        spi_out.sclk  <= 1'b0;
        spi_out.sdi   <= ~spi_out.sdi;
        repeat (4) @(posedge core_clk_in);
        spi_out.csb_n <= 1'b1;
        repeat (8) @(posedge core_clk_in);
    endtask
endmodule

// File: tb/sir_regs_properties.sv
// sir_regs_properties.sv: port-level checks of the serial register block
// assumes: bound to sir_regs_top, one clock domain, reset active high
module sir_regs_properties
(
    input wire logic                   core_clk_in,
    input wire logic                   reset_in,
    input wire sir_pkg::sir_spi_pins_t spi_in,
    input wire logic                   sdo_out,
    input wire logic                   sdo_oe_out,
    input wire logic [3:0]             chan_out_on_out,
    input wire logic                   chan0_sink_en_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking dc @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);

    a_reset_outputs: assert property (
        $fell(reset_in) |-> chan_out_on_out == 4'h0 && chan0_sink_en_out && !sdo_oe_out)
        else $error("outputs wrong after reset release");
    a_chan_quiet_idle: assert property (
        !$stable(chan_out_on_out) |-> !$past(spi_in.csb_n, 2))
        else $error("channel enables moved outside a frame");
    a_sink_quiet_idle: assert property (
        $changed(chan0_sink_en_out) |-> !$past(spi_in.csb_n, 2))
        else $error("sink enable moved outside a frame");
    a_read_no_side: assert property (
        sdo_oe_out |-> $stable(chan_out_on_out) && $stable(chan0_sink_en_out))
        else $error("read frame changed channel control");
    a_oe_needs_select: assert property (
        spi_in.csb_n [*5] |-> !sdo_oe_out)
        else $error("sdo driven while deselected");
    a_oe_ends_frame: assert property (
        $rose(spi_in.csb_n) |-> ##[1:5] !sdo_oe_out)
        else $error("sdo enable outlived the frame");
    a_oe_after_instr: assert property (
        $rose(sdo_oe_out) |-> !$past(spi_in.csb_n, 8) && !spi_in.csb_n)
        else $error("sdo enabled before instruction end");
    a_oe_holds_frame: assert property (
        $fell(sdo_oe_out) |-> $past(spi_in.csb_n, 1) || $past(spi_in.csb_n, 2)
            || $past(spi_in.csb_n, 3) || $past(spi_in.csb_n, 4))
        else $error("sdo enable dropped inside a frame");
    a_sdo_after_fall: assert property (
        $changed(sdo_out) |-> !$past(spi_in.sclk, 2) || !$past(spi_in.sclk, 3)
            || !$past(spi_in.sclk, 4))
        else $error("sdo moved without a serial clock fall");
endmodule

// File: tb/tb_top.sv
// tb_top.sv: self-checking bench of the serial register block
// assumes: sir_pkg compiled first, host model drives the serial pins
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [3:0]  T_CAT   = 4'h6;     // arbitrary value
    localparam logic [15:0] T_PID   = 16'h2a71; // arbitrary value
    localparam logic [3:0]  T_GRADE = 4'h2;     // arbitrary value
    localparam logic [3:0]  T_REV   = 4'h3;     // arbitrary value
    localparam logic [7:0]  T_STD   = 8'h19;    // arbitrary value
    localparam logic [15:0] T_MAKER = 16'h0d3e; // arbitrary value

    logic                   core_clk_in;
    logic                   reset_in;
    logic                   addr_ascend_in;
    sir_pkg::sir_spi_pins_t spi;
    logic                   sdo_out;
    logic [3:0]             chan_out_on_out;
    logic                   chan0_sink_en_out;
    int                     miscompares;
    int                     comparisons;
    int                     cycles;

    sir_regs_top #(.PART_CATEGORY(T_CAT), .PART_ID(T_PID), .GRADE(T_GRADE),
        .REVISION(T_REV), .STD_VERSION(T_STD), .MAKER_ID(T_MAKER)) DUT
    (
        .core_clk_in       (core_clk_in),
        .reset_in          (reset_in),
        .spi_in            (spi),
        .addr_ascend_in    (addr_ascend_in),
        .sdo_out           (sdo_out),
        .sdo_oe_out        (),
        .chan_out_on_out   (chan_out_on_out),
        .chan0_sink_en_out (chan0_sink_en_out)
    );

    sir_host_model host
    (
        .core_clk_in (core_clk_in),
        .sdo_in      (sdo_out),
        .spi_out     (spi)
    );

    // ****************************************************************
    // clock, timeout, tasks
    // ****************************************************************
    always #50 core_clk_in = ~core_clk_in;

    always @(posedge core_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pins(input logic [4:0] got, input logic [4:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // writes of nbits data bits; writable registers are single-byte, so none is split
    task automatic wr(input logic [14:0] a, input int nbits, input logic [63:0] d);
        logic [63:0] r;
        host.frame({1'b0, a}, nbits, d, r);
    endtask

    task automatic rs(input logic [14:0] a, input int n, input logic [63:0] e);
        logic [63:0] r;
        host.frame({1'b1, a}, 8 * n, 64'h0, r);
        for (int k = 0; k < n; k++)
        begin
            chk_byte(r[8 * k +: 8], e[8 * k +: 8]);
        end
    endtask

    task automatic do_reset();
        reset_in <= 1'b1;
        repeat (12) @(posedge core_clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        @(negedge core_clk_in);
        chk_byte({DUT.not_ready_ff, 7'h00}, 8'h80);
        repeat (10) @(posedge core_clk_in);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        core_clk_in    = 1'b0;
        reset_in       = 1'b1;
        addr_ascend_in = 1'b1;
        miscompares    = 0;
        comparisons    = 0;
        cycles         = 0;
        do_reset();
        chk_pins({chan0_sink_en_out, chan_out_on_out}, 5'h10);
        rs(15'h0011, 1, 64'(8'h00));
        rs(15'h0001, 1, 64'(8'h08));
        rs(15'h0010, 1, 64'(8'h20));
        rs(15'h0014, 1, 64'(8'h80));
        rs(15'h000e, 1, 64'(8'h00));
        rs(15'h0020, 1, 64'(8'h00));
        rs(15'h0003, 4, 64'({4'h0, T_CAT, T_PID[7:0], T_PID[15:8], T_GRADE, T_REV}));
        addr_ascend_in <= 1'b0;
        rs(15'h000d, 4, 64'({T_MAKER[15:8], T_MAKER[7:0], T_STD, 8'h00}));
        addr_ascend_in <= 1'b1;
        $display("test reset_and_identity done");
        wr(15'h0001, 8, 64'(8'h57));
        wr(15'h0003, 8, 64'(8'h57));
        wr(15'h000b, 8, 64'(8'h57));
        wr(15'h0010, 8, 64'(8'h57));
        wr(15'h0011, 8, 64'(8'h57));
        rs(15'h0001, 1, 64'(8'h08));
        rs(15'h0003, 1, 64'({4'h0, T_CAT}));
        rs(15'h000b, 1, 64'(T_STD));
        rs(15'h0010, 2, 64'(16'h2000));
        wr(15'h000a, 8, 64'(8'h5a));
        rs(15'h000a, 1, 64'(8'h5a));
        wr(15'h000a, 5, 64'(5'h1f));
        rs(15'h000a, 1, 64'(8'h5a));
        wr(15'h000a, 16, 64'(16'ha533));
        rs(15'h000a, 2, 64'({8'ha5, T_STD}));
        $display("test read_only_and_scratch done");
        for (int n = 0; n < 4; n++)
        begin
            wr(15'h0014, 8, 64'(8'(1 << n)));
            chk_pins({chan0_sink_en_out, chan_out_on_out}, {1'b0, 4'(1 << n)});
        end
        wr(15'h0014, 8, 64'(8'hf5));
        chk_pins({chan0_sink_en_out, chan_out_on_out}, 5'h15);
        rs(15'h0014, 1, 64'(8'h85));
        $display("test channel_control done");
        wr(15'h000e, 8, 64'(8'h02));
        rs(15'h000c, 5, 64'({T_MAKER[7:0], T_MAKER[15:8], T_MAKER[7:0], T_MAKER[15:8],
            T_MAKER[7:0]}));
        wr(15'h000e, 8, 64'(8'h00));
        rs(15'h7ffe, 4, 64'(32'h0000_0008));
        $display("test stream_length done");
        wr(15'h0001, 8, 64'(8'h80));
        rs(15'h0001, 1, 64'(8'h88));
        rs(15'h0003, 2, 64'({4'h0, T_CAT, 8'h00}));
        wr(15'h0001, 8, 64'(8'h00));
        rs(15'h0003, 2, 64'({4'h0, T_CAT, T_PID[7:0]}));
        $display("test one_address done");
        do_reset();
        chk_pins({chan0_sink_en_out, chan_out_on_out}, 5'h10);
        rs(15'h000a, 1, 64'(8'h00));
        rs(15'h0014, 1, 64'(8'h80));
        $display("test second_reset done");
        report_and_stop();
    end
endmodule

bind sir_regs_top sir_regs_properties u_props
(
    .core_clk_in       (core_clk_in),
    .reset_in          (reset_in),
    .spi_in            (spi_in),
    .sdo_out           (sdo_out),
    .sdo_oe_out        (sdo_oe_out),
    .chan_out_on_out   (chan_out_on_out),
    .chan0_sink_en_out (chan0_sink_en_out)
);
